/* upc_cmd_check.sv */
// decides whether a command code is legal in the current phase
// assumes the caller samples the answer only while a command is pending
`timescale 1ns/1ps
`include "upc_map.svh"

module upc_cmd_check (
    // command under test
    input wire upc_pkg::upc_code_t code,
    input wire upc_pkg::upc_phase_e phase,
    // verdict
    output logic valid
);
    import upc_pkg::*;

    always_comb begin
        valid = 1'b0;
        case (code)
            `UPC_CODE_STOP: valid = 1'b1;
            `UPC_CODE_START: valid = (phase == PH_STOPPED) || (phase == PH_TRANSPARENT); // see RULE17
            `UPC_CODE_INIT: valid = (phase == PH_STOPPED); // see RULE19
            `UPC_CODE_SELFTEST: valid = (phase == PH_STOPPED);
            `UPC_CODE_STATUS: valid = 1'b1;
            `UPC_CODE_TRANS: valid = (phase != PH_STOPPED);
            `UPC_CODE_CONN_REQ, `UPC_CODE_CONN_RSP: valid = (phase == PH_DISCONNECTED);
            `UPC_CODE_RST_REQ, `UPC_CODE_RST_RSP: valid = (phase != PH_STOPPED);
            `UPC_CODE_XID_REQ, `UPC_CODE_XID_RSP, `UPC_CODE_TEST_REQ: valid = (phase != PH_STOPPED);
            default: valid = 1'b0;
        endcase
    end

endmodule

/* upc_command_port.sv */
// host command port of a link-level controller: apb registers, command execution, phase control
// assumes one clock, synchronous inputs and an apb master that holds each request until pready
//
// Operation
// RULE1: set rx done after good frame descriptor update
// RULE2: rx done raises interrupt when enabled
// RULE3: rx done cleared by write one, stop
// RULE4: status bit zero always reads zero
// RULE5: conflicting command sets command error flag
// RULE6: command error cleared by write one
// RULE7: pending flag set by software, cleared when done
// RULE8: parameter zero: resend unacknowledged frames on link
// RULE9: parameter one: discard unacknowledged, return ownership
// RULE10: software writes parameter zero otherwise
// RULE11: software writes code with pending flag
// RULE12: stop: stopped phase, no dma, ones, ignore
// RULE13: stop during transmission aborts the frame
// RULE14: stop with parameter one is full reset
// RULE15: start zero: disconnected, rings reset, flags
// RULE16: start one: straight to information transfer
// RULE17: start only when stopped or transparent
// RULE18: interrupt pin low when enabled and flagged
// RULE19: init fetches block, only when stopped
// RULE20: software waits for pending clear first
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "upc_map.svh"

module upc_command_port (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`UPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive side events
    input wire logic rx_desc_upd,
    input wire logic rx_frame_good,
    input wire upc_pkg::upc_frame_e rx_frame_kind,
    // transmit and link events
    input wire logic tx_busy,
    input wire logic link_up,
    // interrupt pin
    output logic irq_n,
    // engine controls
    output logic dma_enable,
    output logic tx_send_ones,
    output logic tx_send_flags,
    output logic rx_ignore,
    output logic [1:0] phase_out,
    // one-cycle command pulses
    output logic ring_reset,
    output logic tx_abort,
    output logic init_fetch_req,
    output logic retx_unacked_req,
    output logic discard_unacked_req,
    output logic cmd_done
);
    import upc_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic rx_done;
        logic irq_en;
        logic cmd_err;
        logic cmd_pend;
        logic cmd_param;
        upc_code_t cmd_code;
        upc_phase_e phase;
        logic armed;
        logic discard_sel;
        logic ring_reset;
        logic tx_abort;
        logic init_req;
        logic retx_req;
        logic discard_req;
        logic done;
    } upc_state_s;

    localparam upc_state_s RESET_STATE = '{
        ack: 1'b0,
        rdata: `UPC_ZERO32,
        rx_done: 1'b0,
        irq_en: 1'b0,
        cmd_err: 1'b0,
        cmd_pend: 1'b0,
        cmd_param: 1'b0,
        cmd_code: `UPC_CODE_STOP,
        phase: PH_STOPPED,
        armed: 1'b0,
        discard_sel: 1'b0,
        ring_reset: 1'b0,
        tx_abort: 1'b0,
        init_req: 1'b0,
        retx_req: 1'b0,
        discard_req: 1'b0,
        done: 1'b0
    };

    upc_state_s s_q;
    upc_state_s s_d;
    logic cmd_valid;

    // low byte lanes carry every field of the 16-bit registers
    function automatic logic lane_ok(input logic [3:0] strb, input int bit_pos);
        lane_ok = strb[bit_pos / 8];
    endfunction

    function automatic logic addr_mapped(input logic [`UPC_ADDR_W-1:0] a);
        addr_mapped = (a == `UPC_OFF_STATUS) || (a == `UPC_OFF_CMD) || (a == `UPC_OFF_PHASE);
    endfunction

    function automatic logic summary_flag(input upc_state_s st);
        summary_flag = st.rx_done;
    endfunction

    upc_cmd_check u_check (
        .code(s_q.cmd_code),
        .phase(s_q.phase),
        .valid(cmd_valid)
    );

    logic access;
    logic wr_fire;
    logic rx_event;
    logic [31:0] status_word;
    logic [31:0] cmd_word;
    logic [31:0] phase_word;

    assign access = psel && penable;
    // writes land only at the edge where pready is seen high
    assign wr_fire = access && s_q.ack && pwrite && addr_mapped(paddr);

    // stopped phase ignores received data entirely
    assign rx_event = rx_desc_upd && rx_frame_good && (s_q.phase != PH_STOPPED)
        && ((s_q.phase == PH_TRANSPARENT) || (rx_frame_kind != FR_OTHER)); // see RULE1

    always_comb begin
        status_word = `UPC_ZERO32;
        status_word[`UPC_ST_RXDONE] = s_q.rx_done;
        status_word[`UPC_ST_IRQ] = summary_flag(s_q);
        status_word[`UPC_ST_IEN] = s_q.irq_en;
        status_word[`UPC_ST_ZERO] = 1'b0; // see RULE4
    end

    always_comb begin
        cmd_word = `UPC_ZERO32;
        cmd_word[`UPC_CM_ERR] = s_q.cmd_err;
        cmd_word[`UPC_CM_PEND] = s_q.cmd_pend;
        cmd_word[`UPC_CM_PARAM] = s_q.cmd_param;
        cmd_word[`UPC_CM_CODE_HI:`UPC_CM_CODE_LO] = s_q.cmd_code;
    end

    always_comb begin
        phase_word = `UPC_ZERO32;
        phase_word[`UPC_PH_HI:`UPC_PH_LO] = s_q.phase;
        phase_word[`UPC_PH_ARMED] = s_q.armed;
        phase_word[`UPC_PH_DISCARD] = s_q.discard_sel;
    end

    always_comb begin
        s_d = s_q;
        s_d.ring_reset = 1'b0;
        s_d.tx_abort = 1'b0;
        s_d.init_req = 1'b0;
        s_d.retx_req = 1'b0;
        s_d.discard_req = 1'b0;
        s_d.done = 1'b0;

        // one wait state so that read data comes from a register
        s_d.ack = access && !s_q.ack;
        if (access && !s_q.ack) begin
            case (paddr)
                `UPC_OFF_STATUS: s_d.rdata = status_word;
                `UPC_OFF_CMD: s_d.rdata = cmd_word;
                `UPC_OFF_PHASE: s_d.rdata = phase_word;
                default: s_d.rdata = `UPC_ZERO32;
            endcase
        end

        // software side of the registers
        if (wr_fire && (paddr == `UPC_OFF_STATUS)) begin
            if (lane_ok(pstrb, `UPC_ST_RXDONE) && pwdata[`UPC_ST_RXDONE]) begin
                s_d.rx_done = 1'b0; // see RULE3
            end
            if (lane_ok(pstrb, `UPC_ST_IEN)) begin
                // enabling is refused while stopped
                s_d.irq_en = pwdata[`UPC_ST_IEN] && (s_q.phase != PH_STOPPED);
            end
        end
        if (wr_fire && (paddr == `UPC_OFF_CMD) && lane_ok(pstrb, `UPC_CM_ERR)) begin
            if (pwdata[`UPC_CM_ERR]) begin
                s_d.cmd_err = 1'b0; // see RULE6
            end
            // a command is latched only together with the pending flag
            if (pwdata[`UPC_CM_PEND]) begin
                s_d.cmd_pend = 1'b1; // see RULE7
                s_d.cmd_param = pwdata[`UPC_CM_PARAM];
                s_d.cmd_code = pwdata[`UPC_CM_CODE_HI:`UPC_CM_CODE_LO];
            end
        end

        // link established: settle the frames left unacknowledged
        if (link_up && (s_q.phase == PH_DISCONNECTED || s_q.phase == PH_INFO)) begin
            s_d.phase = PH_INFO;
            if (s_q.armed) begin
                s_d.armed = 1'b0;
                s_d.retx_req = !s_q.discard_sel; // see RULE8
                s_d.discard_req = s_q.discard_sel; // see RULE9
            end
        end

        // command execution, one cycle after the pending flag is seen
        if (s_q.cmd_pend) begin
            s_d.cmd_pend = 1'b0; // see RULE7
            s_d.done = 1'b1;
            if (!cmd_valid) begin
                s_d.cmd_err = 1'b1; // see RULE5
            end else begin
                case (s_q.cmd_code)
                    `UPC_CODE_STOP: begin
                        s_d.phase = PH_STOPPED; // see RULE12
                        s_d.rx_done = 1'b0; // see RULE3
                        s_d.irq_en = 1'b0;
                        s_d.armed = 1'b0;
                        s_d.tx_abort = tx_busy; // see RULE13
                    end
                    `UPC_CODE_START: begin
                        if (s_q.cmd_param) begin
                            s_d.phase = PH_INFO; // see RULE16
                        end else begin
                            s_d.phase = PH_DISCONNECTED; // see RULE15
                            s_d.ring_reset = 1'b1;
                        end
                    end
                    `UPC_CODE_INIT: s_d.init_req = 1'b1; // see RULE19
                    `UPC_CODE_TRANS: s_d.phase = PH_TRANSPARENT;
                    `UPC_CODE_CONN_REQ, `UPC_CODE_CONN_RSP: begin
                        s_d.armed = 1'b1;
                        s_d.discard_sel = s_q.cmd_param;
                    end
                    `UPC_CODE_RST_REQ, `UPC_CODE_RST_RSP: begin
                        // in disconnected or transparent phase these are accepted but change nothing
                        if (s_q.phase == PH_INFO) begin
                            s_d.armed = 1'b1;
                            s_d.discard_sel = s_q.cmd_param;
                        end
                    end
                    default: s_d.armed = s_d.armed;
                endcase
            end
        end

        // hardware set wins over a clear in the same cycle, except the full reset of stop with parameter one
        if (rx_event) begin
            s_d.rx_done = 1'b1; // see RULE1
        end

        // stop with parameter one behaves as the reset input
        if (s_q.cmd_pend && cmd_valid && (s_q.cmd_code == `UPC_CODE_STOP) && s_q.cmd_param) begin
            s_d = RESET_STATE; // see RULE14
            s_d.tx_abort = tx_busy; // see RULE13
            s_d.done = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= RESET_STATE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign pready = access && s_q.ack;
    assign pslverr = access && s_q.ack && !addr_mapped(paddr);
    assign prdata = s_q.rdata;

    // pin low only when enabled and flagged
    assign irq_n = !(s_q.irq_en && summary_flag(s_q)); // see RULE2 see RULE18

    assign dma_enable = (s_q.phase != PH_STOPPED); // see RULE12
    assign tx_send_ones = (s_q.phase == PH_STOPPED);
    assign tx_send_flags = (s_q.phase != PH_STOPPED); // see RULE15
    assign rx_ignore = (s_q.phase == PH_STOPPED);
    assign phase_out = s_q.phase;

    assign ring_reset = s_q.ring_reset;
    assign tx_abort = s_q.tx_abort;
    assign init_fetch_req = s_q.init_req;
    assign retx_unacked_req = s_q.retx_req;
    assign discard_unacked_req = s_q.discard_req;
    assign cmd_done = s_q.done;

endmodule

/* upc_command_port_chk.sv */
// concurrent checks on the pins of the command port
// assumes one clock domain and is bound onto every upc_command_port instance
`timescale 1ns/1ps

module upc_command_port_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // observed outputs
    input wire logic irq_n,
    input wire logic dma_enable,
    input wire logic tx_send_ones,
    input wire logic tx_send_flags,
    input wire logic rx_ignore,
    input wire logic [1:0] phase_out,
    input wire logic ring_reset,
    input wire logic tx_abort,
    input wire logic init_fetch_req,
    input wire logic retx_unacked_req,
    input wire logic discard_unacked_req,
    input wire logic cmd_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_STOP_OUTS: assert property (phase_out == 2'd0 |-> tx_send_ones && !dma_enable && rx_ignore)
        else $error("stopped phase outputs wrong");
    AST_DISC_FLAGS: assert property (phase_out == 2'd1 |-> tx_send_flags && !tx_send_ones)
        else $error("disconnected phase does not send flags");
    AST_RING_START: assert property (ring_reset |-> phase_out == 2'd1 && !$past(ring_reset))
        else $error("ring reset outside start");
    AST_ABORT_STOP: assert property (tx_abort |-> phase_out == 2'd0)
        else $error("abort without stop");
    AST_INFO_NO_START: assert property (phase_out == 2'd2 |=> phase_out != 2'd1)
        else $error("start accepted in info phase");
    AST_IRQ_STOPPED: assert property ((phase_out == 2'd0) [*3] |-> irq_n)
        else $error("interrupt pin low while stopped");
    AST_DONE_PULSE: assert property (cmd_done |=> !cmd_done)
        else $error("command done longer than one cycle");
    AST_DISCARD_INFO: assert property (discard_unacked_req |-> phase_out == 2'd2 && !retx_unacked_req)
        else $error("discard outside new link");
    AST_RETX_INFO: assert property (retx_unacked_req |-> phase_out == 2'd2)
        else $error("resend outside new link");
    AST_INIT_STOPPED: assert property (init_fetch_req |-> phase_out == 2'd0)
        else $error("init fetch outside stopped phase");
endmodule

bind upc_command_port upc_command_port_chk upc_command_port_chk_i (.sys_clk(sys_clk), .rst(rst), .irq_n(irq_n),
    .dma_enable(dma_enable), .tx_send_ones(tx_send_ones), .tx_send_flags(tx_send_flags), .rx_ignore(rx_ignore),
    .phase_out(phase_out), .ring_reset(ring_reset), .tx_abort(tx_abort), .init_fetch_req(init_fetch_req),
    .retx_unacked_req(retx_unacked_req), .discard_unacked_req(discard_unacked_req), .cmd_done(cmd_done));

/* upc_command_port_tb.sv */
// self-checking bench: a command table, then status, link, abort and reset cases
// assumes upc_map.svh and upc_pkg are compiled first and the checker is bound
`timescale 1ns/1ps
`include "upc_map.svh"

module upc_command_port_tb;
    import upc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic rx_desc_upd = 1'b0;
    logic link_up = 1'b0;
    logic tx_busy = 1'b0;
    logic rx_good = 1'b1;
    upc_frame_e rx_frame_kind = FR_INFO;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, serr, irq_n, ring_reset, tx_abort, init_fetch_req, retx_unacked_req, discard_unacked_req;
    logic [1:0] phase_out;
    int n_errors = 0, n_compared = 0, cyc = 0;
    int n_ring = 0, n_init = 0, n_retx = 0, n_disc = 0, n_abort = 0;
    // code, param, phase after, error after
    logic [8:0] rows [15] = '{9'h020, 9'h061, 9'h012, 9'h013, 9'h036, 9'h01c, 9'h015, 9'h000, 9'h050,
        9'h0a1, 9'h0d1, 9'h040, 9'h0c1, 9'h081, 9'h031};

    upc_command_port upc_command_port_i (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_desc_upd(rx_desc_upd), .rx_frame_good(rx_good), .rx_frame_kind(rx_frame_kind),
        .tx_busy(tx_busy), .link_up(link_up), .irq_n(irq_n), .dma_enable(), .tx_send_ones(), .tx_send_flags(),
        .rx_ignore(), .phase_out(phase_out), .ring_reset(ring_reset), .tx_abort(tx_abort),
        .init_fetch_req(init_fetch_req), .retx_unacked_req(retx_unacked_req),
        .discard_unacked_req(discard_unacked_req), .cmd_done());

    always #5 sys_clk = ~sys_clk;

    task test_done();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // pulses are counted so that checks need no exact cycle
    always @(posedge sys_clk) begin
        cyc++;
        if (ring_reset === 1'b1) n_ring++;
        if (init_fetch_req === 1'b1) n_init++;
        if (retx_unacked_req === 1'b1) n_retx++;
        if (discard_unacked_req === 1'b1) n_disc++;
        if (tx_abort === 1'b1) n_abort++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task cmd(input logic [4:0] c, input logic p);
        apb(1'b1, `UPC_OFF_CMD, {16'h0000, 2'b01, p, c, 8'h00});
    endtask

    task pulse(input logic lu, input upc_frame_e k);
        @(posedge sys_clk);
        link_up <= lu;
        rx_desc_upd <= !lu;
        rx_frame_kind <= k;
        @(posedge sys_clk);
        link_up <= 1'b0;
        rx_desc_upd <= 1'b0;
    endtask

    task st(input logic [31:0] e);
        apb(1'b0, `UPC_OFF_STATUS, 32'h0000_0000);
        chk("status", e, rdat);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            cmd(rows[i][8:4], rows[i][3]);
            apb(1'b0, `UPC_OFF_CMD, 32'h0000_0000);
            chk("cmd flags", {16'h0000, rows[i][0], 15'h0000}, rdat & 32'h0000_c000);
            apb(1'b0, `UPC_OFF_PHASE, 32'h0000_0000);
            chk("phase", {30'h0, rows[i][2:1]}, rdat & 32'h0000_0003);
            apb(1'b1, `UPC_OFF_CMD, 32'h0000_8000);
        end
        chk("ring resets", 32'd1, n_ring);
        chk("init fetches", 32'd1, n_init);
        $display("test command table done");
        apb(1'b1, `UPC_OFF_STATUS, 32'h0000_0200);
        st(32'h0000_0000);
        cmd(`UPC_CODE_START, 1'b0);
        apb(1'b1, `UPC_OFF_STATUS, 32'h0000_0200);
        pulse(1'b0, FR_INFO);
        st(32'h0000_0302);
        chk("irq pin", 32'h0, {31'h0, irq_n});
        apb(1'b1, `UPC_OFF_STATUS, 32'h0000_0200);
        st(32'h0000_0302);
        apb(1'b1, `UPC_OFF_STATUS, 32'h0000_0202);
        st(32'h0000_0200);
        chk("irq pin", 32'h1, {31'h0, irq_n});
        pulse(1'b0, FR_OTHER);
        st(32'h0000_0200);
        rx_good <= 1'b0;
        pulse(1'b0, FR_INFO);
        rx_good <= 1'b1;
        st(32'h0000_0200);
        pulse(1'b0, FR_UI);
        cmd(`UPC_CODE_STOP, 1'b0);
        st(32'h0000_0000);
        $display("test receive flag done");
        cmd(`UPC_CODE_START, 1'b0);
        cmd(`UPC_CODE_CONN_REQ, 1'b1);
        pulse(1'b1, FR_INFO);
        cmd(`UPC_CODE_RST_REQ, 1'b0);
        pulse(1'b1, FR_INFO);
        apb(1'b0, `UPC_OFF_PHASE, 32'h0000_0000);
        chk("phase", 32'h0000_0002, rdat & 32'h0000_0003);
        chk("discards", 32'd1, n_disc);
        chk("resends", 32'd1, n_retx);
        tx_busy <= 1'b1;
        cmd(`UPC_CODE_STOP, 1'b1);
        // the command executes at the edge after the write, so busy must still stand there
        @(posedge sys_clk);
        tx_busy <= 1'b0;
        apb(1'b0, `UPC_OFF_PHASE, 32'h0000_0000);
        chk("phase", 32'h0000_0000, rdat & 32'h0000_0003);
        chk("aborts", 32'd1, n_abort);
        $display("test link and abort done");
        cmd(`UPC_CODE_CONN_REQ, 1'b0);
        apb(1'b1, `UPC_OFF_CMD, 32'h0000_0000);
        apb(1'b0, `UPC_OFF_CMD, 32'h0000_0000);
        chk("error kept", 32'h0000_8000, rdat & 32'h0000_c000);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, serr});
        chk("unmapped data", 32'h0000_0000, rdat);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, `UPC_OFF_CMD, 32'h0000_0000);
        chk("cmd after reset", 32'h0000_0000, rdat & 32'h0000_c000);
        $display("test refusal and reset done");
        test_done();
    end
endmodule

/* upc_map.svh */
// register offsets, field positions and command codes of the command port
// assumes byte addresses on an apb bus with 32-bit data, one register per aligned word
`ifndef UPC_MAP_SVH
`define UPC_MAP_SVH

`define UPC_ADDR_W 8
`define UPC_OFF_STATUS 8'h00
`define UPC_OFF_CMD 8'h04
`define UPC_OFF_PHASE 8'h08

`define UPC_ST_ZERO 0
`define UPC_ST_RXDONE 1
`define UPC_ST_IRQ 8
`define UPC_ST_IEN 9

`define UPC_CM_ERR 15
`define UPC_CM_PEND 14
`define UPC_CM_PARAM 13
`define UPC_CM_CODE_HI 12
`define UPC_CM_CODE_LO 8

`define UPC_PH_LO 0
`define UPC_PH_HI 1
`define UPC_PH_ARMED 2
`define UPC_PH_DISCARD 3

`define UPC_CODE_STOP 5'h00
`define UPC_CODE_START 5'h01
`define UPC_CODE_INIT 5'h02
`define UPC_CODE_TRANS 5'h03
`define UPC_CODE_STATUS 5'h04
`define UPC_CODE_SELFTEST 5'h05
`define UPC_CODE_CONN_REQ 5'h06
`define UPC_CODE_CONN_RSP 5'h07
`define UPC_CODE_RST_REQ 5'h08
`define UPC_CODE_RST_RSP 5'h09
`define UPC_CODE_XID_REQ 5'h0a
`define UPC_CODE_XID_RSP 5'h0b
`define UPC_CODE_TEST_REQ 5'h0c

`define UPC_ZERO32 32'h0000_0000

`endif

/* upc_pkg.sv */
// types shared by the command port and its command checker
// assumes upc_map.svh is compiled alongside
package upc_pkg;

    typedef enum logic [1:0] {
        PH_STOPPED,
        PH_DISCONNECTED,
        PH_INFO,
        PH_TRANSPARENT
    } upc_phase_e;

    typedef enum logic [1:0] {
        FR_INFO,
        FR_UI,
        FR_FRMR,
        FR_OTHER
    } upc_frame_e;

    typedef logic [4:0] upc_code_t;

endpackage
